/* File: scrs_clk_rst_seq.sv */
// scrs_clk_rst_seq: reset release per clock domain, serial clock divider,
// power-up option capture.
// assumes: hard_reset_n and option_pins are asynchronous board pins;
// ref_clk_p is the received reference clock for fabric and transmit logic.
`timescale 1ns/1ps
module scrs_clk_rst_seq
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     hard_reset_n,
  input  wire logic                     ref_clk_p,
  input  wire logic [scrs_pkg::OPT_W-1:0] option_pins,
  output logic                          core_rst_n,
  output logic                          fabric_rst_n,
  output logic                          sclk_out,
  output logic                          sclk_tick,
  output scrs_pkg::scrs_strap_s         straps
);

  // ----------------------------------------------------------------
  // reset release, one synchroniser per domain
  // ----------------------------------------------------------------
  scrs_rst_sync u_reg_sync
  (
    .clk       (core_clk),
    .arst_n    (hard_reset_n),
    .rst_out_n (core_rst_n)
  );

  // fabric and transmit logic are reset in their own clock's domain
  scrs_rst_sync u_fabric_sync
  (
    .clk       (ref_clk_p),
    .arst_n    (hard_reset_n),
    .rst_out_n (fabric_rst_n)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    scrs_pkg::scrs_state_e               state;
    logic [scrs_pkg::OPT_W-1:0]          opt_s1;
    logic [scrs_pkg::OPT_W-1:0]          opt_s2;
    logic [scrs_pkg::OPT_W-1:0]          first_sample;
    logic [scrs_pkg::SCLK_CNT_W-1:0]     sclk_cnt;
    logic                                sclk;
    logic                                tick;
    logic [scrs_pkg::HOLD_CNT_W-1:0]     hold_cnt;
    scrs_pkg::scrs_strap_s               strap;
  } scrs_core_s;

  scrs_core_s s_reg;
  scrs_core_s s_next;

  // the whole register domain, divider included, sits on core_clk with
  // no intermediate clock; the divided clock is a flop output only
  always_comb
  begin
    s_next        = s_reg;
    s_next.opt_s1 = option_pins;
    s_next.opt_s2 = s_reg.opt_s1;
    s_next.tick   = 1'b0;

    // ----------------------------------------------------------------
    // serial clock divider
    // ----------------------------------------------------------------
    if (s_reg.sclk_cnt == scrs_pkg::SCLK_CNT_LAST)
    begin
      s_next.sclk_cnt = scrs_pkg::SCLK_CNT_ZERO;
      s_next.sclk     = ~s_reg.sclk;
      s_next.tick     = 1'b1;
    end
    else
      s_next.sclk_cnt = s_reg.sclk_cnt + 9'h001;

    // ----------------------------------------------------------------
    // option capture: two samples taken at release, then a hold watch
    // ----------------------------------------------------------------
    unique case (s_reg.state)
      scrs_pkg::ST_IN_RESET:
      begin
        s_next.state = scrs_pkg::ST_SAMPLE_A;
      end
      scrs_pkg::ST_SAMPLE_A:
      begin
        s_next.first_sample = s_reg.opt_s2;
        s_next.state        = scrs_pkg::ST_SAMPLE_B;
      end
      scrs_pkg::ST_SAMPLE_B:
      begin
        s_next.strap.options  = s_reg.opt_s2;
        s_next.strap.valid    = 1'b1;
        s_next.strap.hold_err = (s_reg.opt_s2 != s_reg.first_sample);
        s_next.hold_cnt       = scrs_pkg::HOLD_CNT_ZERO;
        s_next.state          = scrs_pkg::ST_RUN;
      end
      scrs_pkg::ST_RUN:
      begin
        // pins that move inside the hold window are flagged, not re-taken;
        // the captured value stays the one seen at release
        if (s_reg.hold_cnt != scrs_pkg::HOLD_CNT_LAST)
        begin
          s_next.hold_cnt = s_reg.hold_cnt + 4'h1;
          if (s_reg.opt_s2 != s_reg.strap.options)
            s_next.strap.hold_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !core_rst_n)
    begin
      s_reg.state        <= scrs_pkg::ST_IN_RESET;
      // the pin synchroniser keeps running in reset so that the first
      // samples after release already show the pins as held at release
      s_reg.opt_s1       <= option_pins;
      s_reg.opt_s2       <= s_reg.opt_s1;
      s_reg.first_sample <= scrs_pkg::OPT_RESET;
      s_reg.sclk_cnt     <= scrs_pkg::SCLK_CNT_ZERO;
      s_reg.sclk         <= 1'b0;
      s_reg.tick         <= 1'b0;
      s_reg.hold_cnt     <= scrs_pkg::HOLD_CNT_ZERO;
      s_reg.strap        <= '0;
    end
    else
      s_reg <= s_next;
  end

  assign sclk_out  = s_reg.sclk;
  assign sclk_tick = s_reg.tick;
  assign straps    = s_reg.strap;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence sclk_toggles;
    $changed(s_reg.sclk);
  endsequence

  a_sclk_half_period: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    sclk_toggles && $past(rst_n) |-> $past(s_reg.sclk_cnt) == scrs_pkg::SCLK_CNT_LAST)
    else $error("serial clock toggled off the divide point");

  a_tick_with_edge: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    sclk_tick |-> sclk_toggles)
    else $error("serial tick without serial clock edge");

  a_reg_held_reset: assert property (@(posedge core_clk)
    !core_rst_n |=> !straps.valid && !sclk_out && s_reg.state == scrs_pkg::ST_IN_RESET)
    else $error("register domain not held in reset");

  sequence release_seen;
    $rose(core_rst_n) && rst_n;
  endsequence

  a_strap_capture: assert property (@(posedge core_clk) disable iff (!rst_n || !core_rst_n)
    release_seen ##0 (!straps.valid) [*3] |=> straps.valid && straps.options == $past(s_reg.opt_s2))
    else $error("options not captured on the third edge after release");

  a_fabric_release: assert property (@(posedge ref_clk_p)
    $rose(fabric_rst_n) |-> $past(hard_reset_n, 1) && $past(hard_reset_n, 2))
    else $error("fabric reset released early");

  a_fabric_hold: assert property (@(posedge ref_clk_p)
    !hard_reset_n |-> !fabric_rst_n)
    else $error("transmit domain out of reset while hard reset low");

  a_core_release: assert property (@(posedge core_clk)
    $rose(core_rst_n) |-> $past(hard_reset_n, 1) && $past(hard_reset_n, 2))
    else $error("register domain released without synchroniser");

  a_core_immediate: assert property (@(posedge core_clk)
    !hard_reset_n |-> !core_rst_n)
    else $error("register domain not reset at once");

endmodule

/* File: scrs_pkg.sv */
// scrs_pkg: constants and types for the clock and reset sequencing block.
// assumes: the register clock core_clk runs at 100 MHz.
package scrs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned REG_CLK_MHZ    = 100;
  localparam int unsigned SCLK_DIV       = 1000;
  localparam int unsigned SCLK_HALF      = SCLK_DIV / 2;
  localparam int unsigned OPT_HOLD_NS    = 100;
  localparam int unsigned OPT_HOLD_CYC_A = (OPT_HOLD_NS * REG_CLK_MHZ + 999) / 1000;
  localparam int unsigned OPT_HOLD_CYC_B = 10;
  localparam int unsigned OPT_HOLD_CYC   =
    (OPT_HOLD_CYC_A > OPT_HOLD_CYC_B) ? OPT_HOLD_CYC_A : OPT_HOLD_CYC_B;

  localparam int unsigned SCLK_CNT_W = 9;
  localparam int unsigned HOLD_CNT_W = 4;
  localparam int unsigned OPT_W      = 2;
  localparam int unsigned SYNC_STAGES = 2;

  localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_LAST = SCLK_CNT_W'(SCLK_HALF - 1);
  localparam logic [SCLK_CNT_W-1:0] SCLK_CNT_ZERO = 9'h000;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_LAST = HOLD_CNT_W'(OPT_HOLD_CYC - 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_ZERO = 4'h0;
  localparam logic [OPT_W-1:0]      OPT_RESET     = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IN_RESET = 2'h0,
    ST_SAMPLE_A = 2'h1,
    ST_SAMPLE_B = 2'h3,
    ST_RUN      = 2'h2
  } scrs_state_e;

  typedef struct packed {
    logic [OPT_W-1:0] options;
    logic             valid;
    logic             hold_err;
  } scrs_strap_s;

endpackage

/* File: scrs_rst_sync.sv */
// scrs_rst_sync: reset release synchroniser, assert at once, release after two edges.
// assumes: arst_n comes from a pin; clk may be any domain clock.
`timescale 1ns/1ps
module scrs_rst_sync
(
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      rst_out_n
);

  logic [scrs_pkg::SYNC_STAGES-1:0] stage_reg;

  // assertion is asynchronous so logic stops at once; only release is timed
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stage_reg <= 2'h0;
    else
      stage_reg <= {stage_reg[0], 1'b1};
  end

  assign rst_out_n = stage_reg[1];

  a_release_delay: assert property (@(posedge clk)
    $rose(rst_out_n) |-> $past(arst_n, 1) && $past(arst_n, 2))
    else $error("reset released without two clean edges");

  a_assert_immediate: assert property (@(posedge clk)
    !arst_n |-> !rst_out_n)
    else $error("reset output high while reset pin low");

endmodule

/* File: scrs_board_model.sv */
// scrs_board_model: board reset supervisor and reference clock source.
// assumes: the bench asks for reset and option values at core_clk falls.
`timescale 1ns/1ps
module scrs_board_model
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_req_n,
  input  wire logic [scrs_pkg::OPT_W-1:0] opt_req,
  input  wire logic                       bad_hold,
  output logic                            hard_reset_n,
  output logic                            ref_clk_p,
  output logic                            test_rst_n,
  output logic [scrs_pkg::OPT_W-1:0]      option_pins
);
  int unsigned hold_cnt = 0;
  logic        pwr_up_n = 1'b0;
  // test-port reset is the AND of hard reset and a power-up reset, so it is
  // low with the first hard reset and follows later ones for free
  assign test_rst_n = hard_reset_n & pwr_up_n;
  initial ref_clk_p = 1'b0;
  initial option_pins = 2'h0;
  // source runs free, 156.25 MHz nominal
  always #3.2 ref_clk_p = ~ref_clk_p;
  // bench keeps core_clk running before and through reset; hold time scaled down
  assign hard_reset_n = rst_req_n;
  // pins move only in reset, well past release, or six cycles in when bad_hold is set; 20 leaves margin over 10
  always @(negedge core_clk)
  begin
    hold_cnt = hard_reset_n ? hold_cnt + 1 : 0;
    if (hard_reset_n)
      pwr_up_n <= 1'b1;
    // a bad hold moves the pins six cycles after release, inside the window
    if (!hard_reset_n || hold_cnt > 20 || (bad_hold && hold_cnt > 5))
      option_pins <= opt_req;
  end
endmodule

/* File: tb_switch_clock_reset_sequencing.sv */
// tb_switch_clock_reset_sequencing: self-checking bench for scrs_clk_rst_seq.
// assumes: scrs_pkg and scrs_board_model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module tb_switch_clock_reset_sequencing;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  rst_req_n = 1'b1;
  logic                  test_rst_n;
  logic [1:0]            opt_req = 2'h0;
  logic                  bad_hold = 1'b0;
  logic                  hard_reset_n, ref_clk_p, core_rst_n, fabric_rst_n, sclk_out, sclk_tick;
  logic [1:0]            option_pins;
  scrs_pkg::scrs_strap_s straps;
  int                    error_cnt = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  always #5 core_clk = ~core_clk;

  scrs_board_model board (.core_clk(core_clk), .rst_req_n(rst_req_n), .opt_req(opt_req),
    .bad_hold(bad_hold), .hard_reset_n(hard_reset_n), .ref_clk_p(ref_clk_p),
    .test_rst_n(test_rst_n),
    .option_pins(option_pins));
  scrs_clk_rst_seq dut (.core_clk(core_clk), .rst_n(rst_n), .hard_reset_n(hard_reset_n),
    .ref_clk_p(ref_clk_p), .option_pins(option_pins), .core_rst_n(core_rst_n),
    .fabric_rst_n(fabric_rst_n), .sclk_out(sclk_out), .sclk_tick(sclk_tick), .straps(straps));

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task hw_reset(input logic [1:0] v, input logic bad);
    @(negedge core_clk);
    rst_req_n <= 1'b0;
    opt_req <= v;
    bad_hold <= bad;
    #1;
    `CHK(core_rst_n, 1'b0)
    `CHK(fabric_rst_n, 1'b0)
    `CHK(test_rst_n, 1'b0)
    repeat (2) @(negedge core_clk);
    rst_req_n <= 1'b1;
    opt_req <= ~v;
  endtask

  task test_release;
    hw_reset(2'h0, 1'b0);
    @(posedge core_clk);
    #1;
    `CHK(core_rst_n, 1'b0)
    @(posedge core_clk);
    #1;
    `CHK(core_rst_n, 1'b1)
    hw_reset(2'h0, 1'b0);
    @(posedge ref_clk_p);
    #0.1;
    `CHK(fabric_rst_n, 1'b0)
    @(posedge ref_clk_p);
    #0.1;
    `CHK(fabric_rst_n, 1'b1)
  endtask

  task test_capture(input logic [1:0] v, input logic bad);
    int n;
    hw_reset(v, bad);
    n = 0;
    while (straps.valid !== 1'b1 && n < 8)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK(straps.valid, 1'b1)
    if (!bad)
      `CHK(straps.options, v)
    repeat (30) @(posedge core_clk);
    #1;
    `CHK(straps.hold_err, bad)
    if (!bad)
      `CHK(straps.options, v)
  endtask

  task test_local_reset;
    @(negedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(straps, 4'h0)
    `CHK(sclk_out, 1'b0)
    @(negedge core_clk);
    rst_n <= 1'b1;
  endtask

  // two half periods of the serial clock, each exactly half of 1000 cycles
  task test_divider;
    int   n;
    logic s;
    for (int h = 0; h < 3; h++)
    begin
      s = sclk_out;
      n = 0;
      do
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      while (sclk_tick !== 1'b1 && n < 600);
      if (h > 0)
      begin
        `CHK(n, scrs_pkg::SCLK_HALF)
        `CHK(sclk_out, ~s)
      end
    end
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done;
    end
  end

  initial
  begin
    // a real falling edge at time zero so the synchronisers reset at once
    rst_req_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n <= 1'b1;
    test_release;
    for (int i = 0; i < 4; i++)
      test_capture(2'(i), 1'b0);
    test_capture(2'h3, 1'b1);
    test_local_reset;
    test_divider;
    test_done;
  end
endmodule
